// [core/bas_pkg.sv]
package bas_pkg;

  // point counts
  localparam int BAS_NUM_BO = 9;
  localparam int BAS_NUM_IF = 3;

  // command operations
  localparam logic [2:0] BAS_OP_READ  = 3'h0;
  localparam logic [2:0] BAS_OP_WRITE = 3'h1;
  localparam logic [2:0] BAS_OP_OVR   = 3'h2;
  localparam logic [2:0] BAS_OP_REL   = 3'h3;
  localparam logic [2:0] BAS_OP_POLL  = 3'h4;

  // object classes
  localparam logic BAS_OBJ_BO = 1'b0;
  localparam logic BAS_OBJ_IF = 1'b1;

  // attribute numbers
  localparam logic [2:0] BAS_ATTR_CFG     = 3'h1;
  localparam logic [2:0] BAS_ATTR_STAT    = 3'h2;
  localparam logic [2:0] BAS_ATTR_IF_STAT = 3'h1;
  localparam logic [2:0] BAS_ATTR_IF_VAL  = 3'h2;

  // field positions
  localparam int BAS_COS_BIT = 0;
  localparam int BAS_CUR_BIT = 6;
  localparam int BAS_OVR_BIT = 1;
  localparam int BAS_REL_BIT = 0;

  // float encodings of command codes
  localparam logic [31:0] BAS_FLT_ZERO  = 32'h0000_0000;
  localparam logic [31:0] BAS_FLT_WRITE = 32'h3F80_0000;
  localparam logic [31:0] BAS_FLT_READ  = 32'h4000_0000;

  // points that may update the drive bit
  localparam logic [8:0] BAS_BO_DRV_MASK = 9'h007;

  // internal float point indices
  localparam logic [1:0] BAS_IF_MENU = 2'h0;
  localparam logic [1:0] BAS_IF_VAL  = 2'h1;
  localparam logic [1:0] BAS_IF_CODE = 2'h2;

  typedef logic [7:0] bas_byte_t;

  // binary output status byte
  function automatic bas_byte_t bas_bo_stat(input logic cur, input logic ovr,
                                            input logic rel);
    bas_byte_t s;
    s = 8'h00;
    s[BAS_CUR_BIT] = cur;
    s[BAS_OVR_BIT] = ovr;
    s[BAS_REL_BIT] = rel;
    return s;
  endfunction

  // internal float status byte
  function automatic bas_byte_t bas_if_stat(input logic tripped);
    bas_byte_t s;
    s = 8'h00;
    s[BAS_REL_BIT] = tripped;
    return s;
  endfunction

endpackage

// [core/bas_bo_eval.sv]
`timescale 1ns/10ps
module bas_bo_eval #(
  parameter int N = 9
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [N-1:0] value,
  input  wire logic [N-1:0] src_bad,
  input  wire logic [N-1:0] src_multibit,
  input  wire logic [N-1:0] term_not_out,
  output logic      [N-1:0] cur_q,
  output logic      [N-1:0] rel_q
);

  // refuse an empty point set at elaboration
  if (N < 1) begin : g_bad_n
    $error("bas_bo_eval: N must be positive");
  end

  // sample the drive output bits
  always_ff @(posedge clock) begin
    if (rst) begin
      cur_q <= '0;
    end else begin
      cur_q <= value;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rel_q <= '0;
    end else begin
      rel_q <= src_bad | src_multibit | term_not_out;
    end
  end

endmodule

// [core/bas_prm_seq.sv]
`timescale 1ns/10ps
module bas_prm_seq (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        start_rd,
  input  wire logic        start_wr,
  input  wire logic [31:0] wdata,
  input  wire logic        ack,
  input  wire logic [31:0] rdata,
  output logic             rd_req,
  output logic             wr_req,
  output logic [31:0]      wdata_q,
  output logic             done_rd,
  output logic [31:0]      rd_data_q
);

  typedef enum logic [1:0] {SQ_IDLE, SQ_RD, SQ_WR} bas_sq_e;
  bas_sq_e st_q;

  // request level follows the state
  assign rd_req = (st_q == SQ_RD);
  assign wr_req = (st_q == SQ_WR);

  // access sequencer, read has priority
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= SQ_IDLE;
    end else begin
      case (st_q)
        SQ_IDLE: begin
          if (start_rd) st_q <= SQ_RD;
          else if (start_wr) st_q <= SQ_WR;
        end
        SQ_RD, SQ_WR: begin
          if (ack) st_q <= SQ_IDLE;
        end
        default: st_q <= SQ_IDLE;
      endcase
    end
  end

  // write data held for the request
  always_ff @(posedge clock) begin
    if (rst) begin
      wdata_q <= 32'h0000_0000;
    end else if (st_q == SQ_IDLE && start_wr) begin
      wdata_q <= wdata;
    end
  end

  // read data and done pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      done_rd   <= 1'b0;
      rd_data_q <= 32'h0000_0000;
    end else begin
      done_rd <= (st_q == SQ_RD) && ack;
      if (st_q == SQ_RD && ack) rd_data_q <= rdata;
    end
  end

endmodule

// [core/bas_pt_core.sv]
`timescale 1ns/10ps
module bas_pt_core
#(
  parameter int NUM_BO = bas_pkg::BAS_NUM_BO
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              cmd_valid,
  input  wire logic [2:0]        cmd_op,
  input  wire logic              cmd_obj,
  input  wire logic [3:0]        cmd_point,
  input  wire logic [2:0]        cmd_attr,
  input  wire logic [31:0]       cmd_wdata,
  output logic                   rsp_valid,
  output logic                   rsp_ok,
  output bas_pkg::bas_byte_t     rsp_status,
  output logic [31:0]            rsp_data,
  output logic [NUM_BO-1:0]      rsp_cos_mask,
  input  wire logic [NUM_BO-1:0] drv_bo_value,
  input  wire logic [NUM_BO-1:0] drv_src_bad,
  input  wire logic [NUM_BO-1:0] drv_src_multibit,
  input  wire logic [NUM_BO-1:0] drv_term_not_out,
  input  wire logic              drv_tripped,
  output logic                   drv_bit_wr,
  output logic [3:0]             drv_bit_idx,
  output logic                   drv_bit_val,
  output logic                   prm_rd_req,
  output logic                   prm_wr_req,
  output logic [31:0]            prm_addr,
  output logic [31:0]            prm_wdata,
  input  wire logic              prm_exists,
  input  wire logic              prm_ack,
  input  wire logic [31:0]       prm_rdata
);
  import bas_pkg::*;

  // point count must cover the writable points and fit the point field
  if (NUM_BO < 3 || NUM_BO > 16) begin : g_bad_num_bo
    $error("bas_pt_core: NUM_BO out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [NUM_BO-1:0] cos_en_q;
  logic [NUM_BO-1:0] ovr_q;
  logic [NUM_BO-1:0] ovr_val_q;
  logic [NUM_BO-1:0] rep_q;
  logic [NUM_BO-1:0] eval_cur;
  logic [NUM_BO-1:0] eval_rel;
  logic [NUM_BO-1:0] cur_now;
  logic [NUM_BO-1:0] drv_mask;
  logic [31:0]       ifv_q  [BAS_NUM_IF];
  logic              bo_hit;
  logic              if_hit;
  logic              is_poll;
  logic              cmd_ok;
  logic              bo_ovr;
  logic              bo_rel;
  logic              if_ovr;
  logic              start_rd;
  logic              start_wr;
  logic              done_rd;
  logic [31:0]       rd_data;
  logic [1:0]        if_idx;

  assign drv_mask = NUM_BO'(BAS_BO_DRV_MASK);
  assign prm_addr = ifv_q[BAS_IF_MENU];
  assign if_idx   = cmd_point[1:0];

  ////////////////////////////////////////////////////////////////////////
  // drive side evaluation and parameter sequencer

  bas_bo_eval #(
    .N (NUM_BO)
  ) u_eval (
    .clock        (clock),
    .rst          (rst),
    .value        (drv_bo_value),
    .src_bad      (drv_src_bad),
    .src_multibit (drv_src_multibit),
    .term_not_out (drv_term_not_out),
    .cur_q        (eval_cur),
    .rel_q        (eval_rel)
  );

  bas_prm_seq u_seq (
    .clock     (clock),
    .rst       (rst),
    .start_rd  (start_rd),
    .start_wr  (start_wr),
    .wdata     (cmd_wdata),
    .ack       (prm_ack),
    .rdata     (prm_rdata),
    .rd_req    (prm_rd_req),
    .wr_req    (prm_wr_req),
    .wdata_q   (prm_wdata),
    .done_rd   (done_rd),
    .rd_data_q (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // command decode

  assign bo_hit  = cmd_valid && cmd_obj == BAS_OBJ_BO && 32'(cmd_point) < NUM_BO;
  assign if_hit  = cmd_valid && cmd_obj == BAS_OBJ_IF && 32'(cmd_point) < BAS_NUM_IF;
  assign is_poll = cmd_valid && cmd_op == BAS_OP_POLL;
  assign bo_ovr  = bo_hit && cmd_op == BAS_OP_OVR && cmd_attr == BAS_ATTR_STAT;
  assign bo_rel  = bo_hit && cmd_op == BAS_OP_REL;
  // only the value attribute is overridden
  assign if_ovr  = if_hit && cmd_op == BAS_OP_OVR && cmd_attr == BAS_ATTR_IF_VAL;

  // write gated by existence and code
  assign start_wr = if_ovr && if_idx == BAS_IF_VAL && prm_exists
                    && ifv_q[BAS_IF_CODE] == BAS_FLT_WRITE;
  assign start_rd = if_ovr && if_idx == BAS_IF_CODE && cmd_wdata == BAS_FLT_READ;

  // current state follows drive unless overridden
  assign cur_now = (ovr_q & ovr_val_q) | (~ovr_q & eval_cur);

  // acceptance of a command
  always_comb begin
    cmd_ok = 1'b0;
    if (is_poll) begin
      cmd_ok = 1'b1;
    end else if (bo_hit) begin
      case (cmd_op)
        BAS_OP_READ:  cmd_ok = cmd_attr == BAS_ATTR_CFG || cmd_attr == BAS_ATTR_STAT;
        BAS_OP_WRITE: cmd_ok = cmd_attr == BAS_ATTR_CFG;
        BAS_OP_OVR:   cmd_ok = cmd_attr == BAS_ATTR_STAT;
        BAS_OP_REL:   cmd_ok = 1'b1;
        default:      cmd_ok = 1'b0;
      endcase
    end else if (if_hit) begin
      case (cmd_op)
        BAS_OP_READ: cmd_ok = cmd_attr == BAS_ATTR_IF_STAT
                              || cmd_attr == BAS_ATTR_IF_VAL;
        BAS_OP_OVR:  cmd_ok = cmd_attr == BAS_ATTR_IF_VAL;
        BAS_OP_REL:  cmd_ok = 1'b1;
        default:     cmd_ok = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // binary output points

  always_ff @(posedge clock) begin
    if (rst) begin
      cos_en_q <= '0;
    end else if (bo_hit && cmd_op == BAS_OP_WRITE && cmd_attr == BAS_ATTR_CFG) begin
      // only the enable bit is kept
      cos_en_q[cmd_point] <= cmd_wdata[BAS_COS_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ovr_q     <= '0;
      ovr_val_q <= '0;
    end else if (bo_ovr) begin
      ovr_q[cmd_point]     <= 1'b1;
      ovr_val_q[cmd_point] <= cmd_wdata[0];
    end else if (bo_rel) begin
      ovr_q[cmd_point] <= 1'b0;
    end
  end

  // writable points update drive, others not
  always_ff @(posedge clock) begin
    if (rst) begin
      drv_bit_wr  <= 1'b0;
      drv_bit_idx <= 4'h0;
      drv_bit_val <= 1'b0;
    end else begin
      drv_bit_wr <= bo_ovr && drv_mask[cmd_point];
      if (bo_ovr && drv_mask[cmd_point]) begin
        drv_bit_idx <= cmd_point;
        drv_bit_val <= cmd_wdata[0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rep_q <= '0;
    end else if (is_poll) begin
      rep_q <= (cos_en_q & cur_now) | (~cos_en_q & rep_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // internal float points

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < BAS_NUM_IF; i++) ifv_q[i] <= BAS_FLT_ZERO;
    end else begin
      if (if_ovr) ifv_q[if_idx] <= cmd_wdata;
      // fetched value lands, point 0 cleared
      if (done_rd) begin
        ifv_q[BAS_IF_VAL]  <= rd_data;
        ifv_q[BAS_IF_MENU] <= BAS_FLT_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reply

  // fresh evaluation on every query and poll
  always_ff @(posedge clock) begin
    if (rst) begin
      rsp_valid    <= 1'b0;
      rsp_ok       <= 1'b0;
      rsp_status   <= 8'h00;
      rsp_data     <= 32'h0000_0000;
      rsp_cos_mask <= '0;
    end else begin
      rsp_valid    <= cmd_valid;
      rsp_ok       <= cmd_ok;
      rsp_status   <= 8'h00;
      rsp_data     <= 32'h0000_0000;
      rsp_cos_mask <= '0;
      if (is_poll) begin
        // only output points in the mask
        rsp_cos_mask <= cos_en_q & (cur_now ^ rep_q);
      end else if (bo_hit && cmd_op == BAS_OP_READ && cmd_ok) begin
        rsp_status <= bas_bo_stat(cur_now[cmd_point], ovr_q[cmd_point],
                                  eval_rel[cmd_point]);
        if (cmd_attr == BAS_ATTR_CFG) begin
          rsp_data <= {31'h0000_0000, cos_en_q[cmd_point]};
        end else begin
          rsp_data <= {31'h0000_0000, cur_now[cmd_point]};
        end
      end else if (if_hit && cmd_op == BAS_OP_READ && cmd_ok) begin
        rsp_status <= bas_if_stat(drv_tripped);
        rsp_data   <= ifv_q[if_idx];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  AST_BO_STAT_NO_WRITE: assert property (@(posedge clock) disable iff (rst)
    bo_hit && cmd_op == BAS_OP_WRITE && cmd_attr == BAS_ATTR_STAT
    |=> rsp_valid && !rsp_ok)
    else $error("status write accepted");

  AST_IF_STAT_NO_OVR: assert property (@(posedge clock) disable iff (rst)
    if_hit && cmd_op == BAS_OP_OVR && cmd_attr == BAS_ATTR_IF_STAT
    |=> rsp_valid && !rsp_ok && $stable(ifv_q[$past(if_idx)]))
    else $error("float status override accepted");

  AST_OVR_SET: assert property (@(posedge clock) disable iff (rst)
    bo_ovr |=> ovr_q[$past(cmd_point)] && ovr_val_q[$past(cmd_point)] == $past(cmd_wdata[0]))
    else $error("override flag not set");

  AST_OVR_CLEAR: assert property (@(posedge clock) disable iff (rst)
    (|($past(ovr_q) & ~ovr_q)) |-> $past(bo_rel))
    else $error("override cleared without release");

  AST_RO_NO_DRIVE: assert property (@(posedge clock) disable iff (rst)
    bo_ovr && !drv_mask[cmd_point] |=> !drv_bit_wr)
    else $error("read-only point drove the drive");

  AST_RW_DRIVE: assert property (@(posedge clock) disable iff (rst)
    bo_ovr && drv_mask[cmd_point]
    |=> drv_bit_wr && drv_bit_idx == $past(cmd_point) && drv_bit_val == $past(cmd_wdata[0]))
    else $error("writable point not driven");

  AST_CUR_MIRROR: assert property (@(posedge clock) disable iff (rst)
    bo_hit && cmd_op == BAS_OP_READ && cmd_attr == BAS_ATTR_STAT && !ovr_q[cmd_point]
    |=> rsp_status[BAS_CUR_BIT] == $past(eval_cur[cmd_point]))
    else $error("current state does not mirror drive");

  AST_IF_TRIP: assert property (@(posedge clock) disable iff (rst)
    if_hit && cmd_op == BAS_OP_READ && cmd_ok
    |=> rsp_status == bas_if_stat($past(drv_tripped)))
    else $error("float status wrong");

  AST_PRM_WR_GATE: assert property (@(posedge clock) disable iff (rst)
    $rose(prm_wr_req) |-> $past(ifv_q[BAS_IF_CODE]) == BAS_FLT_WRITE && $past(prm_exists))
    else $error("parameter write without code 1");

  AST_RD_CLEAR: assert property (@(posedge clock) disable iff (rst)
    done_rd |=> ifv_q[BAS_IF_MENU] == BAS_FLT_ZERO && !prm_rd_req)
    else $error("point 0 not cleared after fetch");

  AST_COS_ONCE: assert property (@(posedge clock) disable iff (rst)
    is_poll ##1 is_poll && $stable(cur_now) && $stable(cos_en_q) |=> rsp_cos_mask == '0)
    else $error("change reported twice");

  AST_COS_ONCE_GAP: assert property (@(posedge clock) disable iff (rst)
    is_poll ##1 !is_poll ##1 is_poll && cur_now == $past(cur_now, 2)
    && cos_en_q == $past(cos_en_q, 2) |=> rsp_cos_mask == '0)
    else $error("change reported twice after a gap");

  AST_COS_EN: assert property (@(posedge clock) disable iff (rst)
    is_poll |=> (rsp_cos_mask & ~$past(cos_en_q)) == '0)
    else $error("disabled point reported");

  COV_OVERRIDE_RELEASE: cover property (@(posedge clock) disable iff (rst)
    bo_ovr ##[1:20] bo_rel);
  COV_PARAM_READ: cover property (@(posedge clock) disable iff (rst)
    start_rd ##[1:50] done_rd);
  COV_COS_REPORT: cover property (@(posedge clock) disable iff (rst)
    is_poll ##1 (|rsp_cos_mask));

endmodule

// [verif/bas_drv_model.sv]
`timescale 1ns/10ps
module bas_drv_model #(
  parameter logic [31:0] KNOWN_ADDR = 32'h3FA0_0000,
  parameter logic [31:0] INIT_VAL   = 32'h427A_0000
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [3:0]  delay,
  input  wire logic        prm_rd_req,
  input  wire logic        prm_wr_req,
  input  wire logic [31:0] prm_addr,
  input  wire logic [31:0] prm_wdata,
  output logic             prm_exists,
  output logic             prm_ack,
  output logic [31:0]      prm_rdata,
  output logic [7:0]       wr_cnt,
  output logic [31:0]      mem_q
);
  logic [3:0] wait_q;

  ////////////////////////////////////////////////////////////
  // menu and parameter lookup
  assign prm_exists = (prm_addr == KNOWN_ADDR);

  ////////////////////////////////////////////////////////////
  // one ack per request after delay cycles; data line toggles otherwise
  always @(posedge clock) begin
    prm_ack <= 1'b0;
    if (rst) begin
      wait_q    <= 4'h0;
      wr_cnt    <= 8'h00;
      mem_q     <= INIT_VAL;
      prm_rdata <= 32'h0000_0000;
    end else if ((prm_rd_req || prm_wr_req) && !prm_ack) begin
      prm_rdata <= ~prm_rdata;
      wait_q    <= wait_q + 4'h1;
      if (wait_q == delay) begin
        prm_ack   <= 1'b1;
        wait_q    <= 4'h0;
        prm_rdata <= mem_q;
        if (prm_wr_req) begin
          mem_q  <= prm_wdata;
          wr_cnt <= wr_cnt + 8'h01;
        end
      end
    end else begin
      prm_rdata <= ~prm_rdata; // no stale value
    end
  end
endmodule

// [verif/bas_point_objects_param_access_tb.sv]
`timescale 1ns/10ps
module bas_point_objects_param_access_tb;
  import bas_pkg::*;
  localparam logic [31:0] ADDR_OK = 32'h3FA0_0000;
  localparam logic [31:0] INIT_V  = 32'h427A_0000;
  logic              clock, rst, cmd_valid, cmd_obj, rsp_valid, rsp_ok;
  logic              drv_tripped, drv_bit_wr, drv_bit_val;
  logic              prm_rd_req, prm_wr_req, prm_exists, prm_ack;
  logic [2:0]        cmd_op, cmd_attr;
  logic [3:0]        cmd_point, drv_bit_idx, delay;
  logic [31:0]       cmd_wdata, rsp_data, prm_addr, prm_wdata, prm_rdata, mem_q;
  logic [31:0]       r_data;
  logic [8:0]        rsp_cos_mask, drv_bo_value, drv_src_bad, drv_src_multibit;
  logic [8:0]        drv_term_not_out, r_mask;
  logic [7:0]        wr_cnt, n0;
  bas_byte_t         rsp_status, r_stat;
  logic              r_bw, r_bv;
  logic [3:0]        r_bi;
  int                mismatches, tests_run;

  bas_pt_core #(.NUM_BO(9)) dut_u (
    .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_obj(cmd_obj), .cmd_point(cmd_point), .cmd_attr(cmd_attr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
    .rsp_status(rsp_status), .rsp_data(rsp_data), .rsp_cos_mask(rsp_cos_mask),
    .drv_bo_value(drv_bo_value), .drv_src_bad(drv_src_bad),
    .drv_src_multibit(drv_src_multibit), .drv_term_not_out(drv_term_not_out),
    .drv_tripped(drv_tripped), .drv_bit_wr(drv_bit_wr), .drv_bit_idx(drv_bit_idx),
    .drv_bit_val(drv_bit_val), .prm_rd_req(prm_rd_req), .prm_wr_req(prm_wr_req),
    .prm_addr(prm_addr), .prm_wdata(prm_wdata), .prm_exists(prm_exists),
    .prm_ack(prm_ack), .prm_rdata(prm_rdata));

  bas_drv_model drv_u (
    .clock(clock), .rst(rst), .delay(delay), .prm_rd_req(prm_rd_req),
    .prm_wr_req(prm_wr_req), .prm_addr(prm_addr), .prm_wdata(prm_wdata),
    .prm_exists(prm_exists), .prm_ack(prm_ack), .prm_rdata(prm_rdata),
    .wr_cnt(wr_cnt), .mem_q(mem_q));

  ////////////////////////////////////////////////////////////
  // clock source
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////
  // compare and report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one command, answer taken in the cycle after
  task automatic cmd(input logic [2:0] op, input logic obj, input logic [3:0] pt,
                     input logic [2:0] at, input logic [31:0] wd, input logic ok);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_obj   = obj;
    cmd_point = pt;
    cmd_attr  = at;
    cmd_wdata = wd;
    @(negedge clock);
    cmd_valid = 1'b0;
    chk("rsp_valid", 32'h1, rsp_valid);
    chk("rsp_ok", ok, rsp_ok);
    r_stat = rsp_status;
    r_data = rsp_data;
    r_mask = rsp_cos_mask;
    r_bw   = drv_bit_wr;
    r_bi   = drv_bit_idx;
    r_bv   = drv_bit_val;
  endtask

  task automatic rd(input logic obj, input logic [3:0] pt, input logic [2:0] at);
    cmd(BAS_OP_READ, obj, pt, at, 32'h0, 1'b1);
  endtask

  task automatic ov(input logic obj, input logic [3:0] pt, input logic [31:0] wd);
    cmd(BAS_OP_OVR, obj, pt, BAS_ATTR_STAT, wd, 1'b1);
  endtask

  task automatic poll(input logic [8:0] e);
    cmd(BAS_OP_POLL, BAS_OBJ_BO, 4'h0, 3'h0, 32'h0, 1'b1);
    chk("cos mask", e, r_mask);
  endtask

  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_cfg();
    rd(BAS_OBJ_BO, 4'h8, BAS_ATTR_CFG);
    chk("cfg reset", 32'h0, r_data);
    cmd(BAS_OP_WRITE, BAS_OBJ_BO, 4'h8, BAS_ATTR_CFG, 32'hFFFF_FFFF, 1'b1);
    rd(BAS_OBJ_BO, 4'h8, BAS_ATTR_CFG);
    chk("cfg bit", 32'h1, r_data);
    cmd(BAS_OP_WRITE, BAS_OBJ_BO, 4'h8, BAS_ATTR_CFG, 32'hFFFF_FFFE, 1'b1);
    rd(BAS_OBJ_BO, 4'h8, BAS_ATTR_CFG);
    chk("cfg clear", 32'h0, r_data);
  endtask

  task automatic t_poll();
    drv_bo_value = 9'h018;
    cmd(BAS_OP_WRITE, BAS_OBJ_BO, 4'h3, BAS_ATTR_CFG, 32'h1, 1'b1);
    poll(9'h008);
    poll(9'h000);
    drv_bo_value = 9'h010;
    poll(9'h008);
    poll(9'h000);
  endtask

  task automatic t_stat();
    for (int k = 0; k < 5; k++) begin
      drv_bo_value     = (k < 4) ? 9'h040 : 9'h000;
      drv_src_bad      = (k == 0) ? 9'h040 : 9'h000;
      drv_src_multibit = (k == 1) ? 9'h040 : 9'h000;
      drv_term_not_out = (k == 2) ? 9'h040 : 9'h000;
      rd(BAS_OBJ_BO, 4'h6, BAS_ATTR_STAT);
      chk("bo status", (k < 3) ? 8'h41 : ((k == 3) ? 8'h40 : 8'h00), r_stat);
      chk("bo state", (k < 4) ? 32'h1 : 32'h0, r_data);
    end
  endtask

  task automatic t_ovr();
    for (int i = 0; i < 9; i++) begin
      ov(BAS_OBJ_BO, i[3:0], 32'h1);
      chk("drive write", (i < 3), r_bw);
      if (i < 3) begin
        chk("drive index", i, r_bi);
        chk("drive bit", 32'h1, r_bv);
      end
      rd(BAS_OBJ_BO, i[3:0], BAS_ATTR_STAT);
      chk("override status", 8'h42, r_stat);
    end
    cmd(BAS_OP_REL, BAS_OBJ_BO, 4'h0, BAS_ATTR_STAT, 32'h0, 1'b1);
    rd(BAS_OBJ_BO, 4'h0, BAS_ATTR_STAT);
    chk("released status", 8'h00, r_stat);
    rd(BAS_OBJ_BO, 4'h1, BAS_ATTR_STAT);
    chk("held status", 8'h42, r_stat);
    for (int i = 1; i < 9; i++) begin
      cmd(BAS_OP_REL, BAS_OBJ_BO, i[3:0], BAS_ATTR_STAT, 32'h0, 1'b1);
    end
  endtask

  task automatic t_refuse();
    cmd(BAS_OP_WRITE, BAS_OBJ_BO, 4'h0, BAS_ATTR_STAT, 32'h1, 1'b0);
    cmd(BAS_OP_WRITE, BAS_OBJ_IF, 4'h0, BAS_ATTR_IF_STAT, 32'h1, 1'b0);
    cmd(BAS_OP_OVR, BAS_OBJ_IF, 4'h0, BAS_ATTR_IF_STAT, 32'h1, 1'b0);
    cmd(BAS_OP_READ, BAS_OBJ_BO, 4'h9, BAS_ATTR_CFG, 32'h0, 1'b0);
    cmd(3'h5, BAS_OBJ_BO, 4'h0, BAS_ATTR_CFG, 32'h0, 1'b0);
    cmd(BAS_OP_REL, BAS_OBJ_IF, 4'h1, BAS_ATTR_IF_VAL, 32'h0, 1'b1);
    rd(BAS_OBJ_BO, 4'h0, BAS_ATTR_STAT);
    chk("refused no effect", 8'h00, r_stat);
  endtask

  task automatic t_prm_rd();
    int n;
    delay = 4'h0;
    ov(BAS_OBJ_IF, BAS_IF_MENU, ADDR_OK);
    rd(BAS_OBJ_IF, BAS_IF_MENU, BAS_ATTR_IF_VAL);
    chk("menu param", ADDR_OK, r_data);
    ov(BAS_OBJ_IF, BAS_IF_CODE, BAS_FLT_READ);
    n = 0;
    r_data = 32'h1;
    while (r_data !== 32'h0 && n < 20) begin
      rd(BAS_OBJ_IF, BAS_IF_MENU, BAS_ATTR_IF_VAL);
      n++;
    end
    chk("menu cleared", 32'h0, r_data);
    if (r_data !== 32'h0) end_sim();
    rd(BAS_OBJ_IF, BAS_IF_VAL, BAS_ATTR_IF_VAL);
    chk("param value", INIT_V, r_data);
    chk("value status", 8'h00, r_stat);
    drv_tripped = 1'b1;
    rd(BAS_OBJ_IF, BAS_IF_CODE, BAS_ATTR_IF_STAT);
    chk("trip status", 8'h01, r_stat);
    drv_tripped = 1'b0;
  endtask

  task automatic t_prm_wr();
    delay = 4'h6;
    ov(BAS_OBJ_IF, BAS_IF_MENU, ADDR_OK);
    ov(BAS_OBJ_IF, BAS_IF_CODE, BAS_FLT_WRITE);
    n0 = wr_cnt;
    ov(BAS_OBJ_IF, BAS_IF_VAL, 32'h42C8_0000);
    for (int n = 0; n < 30 && wr_cnt == n0; n++) @(negedge clock);
    chk("write count", n0 + 8'h01, wr_cnt);
    chk("written value", 32'h42C8_0000, mem_q);
    if (wr_cnt == n0) end_sim();
    n0 = wr_cnt;
    ov(BAS_OBJ_IF, BAS_IF_MENU, 32'h4120_0000);
    ov(BAS_OBJ_IF, BAS_IF_VAL, 32'h4000_0000);
    ov(BAS_OBJ_IF, BAS_IF_MENU, ADDR_OK);
    ov(BAS_OBJ_IF, BAS_IF_CODE, BAS_FLT_ZERO);
    ov(BAS_OBJ_IF, BAS_IF_VAL, 32'h4000_0000);
    repeat (12) @(negedge clock);
    chk("no write", n0, wr_cnt);
    poll(9'h000);
  endtask

  ////////////////////////////////////////////////////////////
  // reset then run every scenario
  initial begin
    mismatches = 0;
    tests_run = 0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_obj = 1'b0;
    cmd_point = 4'h0;
    cmd_attr = 3'h0;
    cmd_wdata = 32'h0;
    drv_bo_value = 9'h000;
    drv_src_bad = 9'h000;
    drv_src_multibit = 9'h000;
    drv_term_not_out = 9'h000;
    drv_tripped = 1'b0;
    delay = 4'h0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_cfg();
    t_poll();
    t_stat();
    t_ovr();
    t_refuse();
    t_prm_rd();
    t_prm_wr();
    end_sim();
  end
endmodule
